// file: rtl/table_access.v
/*
 Table read / table write execution unit of an 8-bit core.
 Assumes the core presents one instruction word with instr_valid in the
 decode phase (Q1) of its first cycle, waits while busy is high, and that
 program memory answers mem_rdata combinationally from mem_addr.
*/
// Notes on behaviour
// R1 - word 0x0008..0x000B is table read: memory byte at pointer into latch
// R2 - mode 0 keep, 1 post-increment, 2 post-decrement, 3 pre-increment pointer
// R3 - pointer is 21-bit byte address; steps are exactly one byte
// R4 - pointer bit 0 picks low (clear) or high (set) byte of a word
// R5 - one word, two cycles; source read and latch written Q2, holding register written Q4 of cycle two
// R6 - word 0x000C..0x000F is table write: latch into a holding register
// R7 - low three pointer bits after pre-increment choose the holding register
// R8 - write updates pointer as read does and leaves latch unchanged
// R9 - no status flags touched; pointer arithmetic wraps at 21 bits
`include "table_access_defines.vh"

module table_access #(
   parameter HOLD_DEPTH = 8
) (
   // clock, reset, enable
   input wire mclk,
   input wire rst_n,
   input wire clk_en,
   // instruction from core
   input wire [15:0] instr,
   input wire instr_valid,
   // program memory read port
   input wire [15:0] mem_rdata,
   output reg [`PTR_WIDTH-2:0] mem_addr,
   // results
   output reg [`PTR_WIDTH-1:0] table_pointer,
   output reg [7:0] table_latch,
   output reg [8*HOLD_DEPTH-1:0] hold_flat,
   output reg hold_wr,
   output reg [`HOLD_SEL_BITS-1:0] hold_sel,
   output reg busy,
   output reg done
);

   localparam ST_IDLE = 2'h0;
   localparam ST_CYC1 = 2'h1;
   localparam ST_CYC2 = 2'h2;

   reg [1:0] state;
   reg [1:0] next_state;
   reg [1:0] phase;
   reg is_write;
   reg [1:0] mode;
   reg [7:0] src_byte;
   reg [`PTR_WIDTH-1:0] access_ptr;
   wire is_table_op;
   wire take;
   wire end_cyc1;
   wire read_slot;
   wire last_slot;
   wire write_slot;
   wire [`PTR_WIDTH-1:0] ptr_inc;
   wire [`PTR_WIDTH-1:0] ptr_dec;
   wire [`PTR_WIDTH-1:0] next_ptr;
   wire [`PTR_WIDTH-1:0] first_ptr;

   // R1 read word decode
   // R6 write word decode
   assign is_table_op = (instr[15:4] == `OPC_PREFIX) &&
                        (instr[3:2] == `OPC_RD_TAG || instr[3:2] == `OPC_WR_TAG);

   // words offered while busy are dropped, not queued
   assign take = (state == ST_IDLE) && instr_valid && is_table_op;

   // R5 phase slots of the two cycles
   assign end_cyc1 = (state == ST_CYC1) && (phase == `PHASE_Q4);
   assign read_slot = (state == ST_CYC2) && (phase == `PHASE_Q2) && !is_write;
   assign last_slot = (state == ST_CYC2) && (phase == `PHASE_Q4);
   assign write_slot = last_slot && is_write;

   // R3 one-byte steps
   // R9 wraps modulo 2^21
   assign ptr_inc = table_pointer + {{(`PTR_WIDTH-1){1'b0}}, 1'b1};
   assign ptr_dec = table_pointer - {{(`PTR_WIDTH-1){1'b0}}, 1'b1};

   // R2 pointer update select
   // R8 same update for writes
   assign next_ptr = (mode == `MODE_POSTINC || mode == `MODE_PREINC) ? ptr_inc :
                     (mode == `MODE_POSTDEC) ? ptr_dec : table_pointer;

   // pre-increment: the new address is the one accessed
   assign first_ptr = (mode == `MODE_PREINC) ? ptr_inc : table_pointer;

   // R4 byte within word
   always @* begin
      src_byte = access_ptr[0] ? mem_rdata[15:8] : mem_rdata[7:0];
   end

   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (take)
               next_state = ST_CYC1;
         end
         ST_CYC1: begin
            if (phase == `PHASE_Q4)
               next_state = ST_CYC2;
         end
         ST_CYC2: begin
            if (phase == `PHASE_Q4)
               next_state = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         state <= ST_IDLE;
      else if (clk_en)
         state <= next_state;
   end

   // decode took Q1, so execution opens in Q2
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         phase <= `PHASE_Q1;
      else if (clk_en) begin
         if (take)
            phase <= `PHASE_Q2;
         else if (state != ST_IDLE)
            phase <= phase + 2'h1;
      end
   end

   // the word is held here so the core may change instr at once
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         is_write <= 1'b0;
         mode <= `MODE_NONE;
      end else if (clk_en && take) begin
         is_write <= instr[2];
         mode <= instr[1:0];
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         access_ptr <= `PTR_RESET;
         mem_addr <= {(`PTR_WIDTH-1){1'b0}};
      end else if (clk_en && end_cyc1) begin
         access_ptr <= first_ptr;
         mem_addr <= first_ptr[`PTR_WIDTH-1:1];
      end
   end

   // R5 source read in Q2
   // R1 memory byte into latch
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         table_latch <= `LATCH_RESET;
      else if (clk_en && read_slot)
         table_latch <= src_byte;
   end

   // R5 pointer written in Q4
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         table_pointer <= `PTR_RESET;
      else if (clk_en && last_slot)
         table_pointer <= next_ptr;
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         busy <= 1'b0;
      else if (clk_en) begin
         if (take)
            busy <= 1'b1;
         else if (last_slot)
            busy <= 1'b0;
      end
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         done <= 1'b0;
      else if (clk_en)
         done <= last_slot;
   end

   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         hold_wr <= 1'b0;
      else if (clk_en)
         hold_wr <= write_slot;
   end

   // R7 holding register select
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         hold_sel <= {`HOLD_SEL_BITS{1'b0}};
      else if (clk_en && write_slot)
         hold_sel <= access_ptr[`HOLD_SEL_BITS-1:0];
   end

   // R6 latch into holding register
   // R8 latch itself untouched on write
   genvar k;
   generate
      for (k = 0; k < HOLD_DEPTH; k = k + 1) begin : g_hold
         localparam [`HOLD_SEL_BITS-1:0] SEL = k;
         always @(posedge mclk or negedge rst_n) begin
            if (!rst_n)
               hold_flat[8*k +: 8] <= 8'h00;
            else if (clk_en && write_slot && access_ptr[`HOLD_SEL_BITS-1:0] == SEL)
               hold_flat[8*k +: 8] <= table_latch;
         end
      end
   endgenerate

endmodule // table_access

// file: rtl/table_access_defines.vh
/*
 Constants for the table-access execution unit: opcode fields,
 pointer modes, phase and pointer widths. Assumes plain inclusion by name.
*/
`ifndef TABLE_ACCESS_DEFINES_VH
`define TABLE_ACCESS_DEFINES_VH
`define OPC_PREFIX 12'h000
`define OPC_RD_TAG 2'h2
`define OPC_WR_TAG 2'h3
`define MODE_NONE 2'h0
`define MODE_POSTINC 2'h1
`define MODE_POSTDEC 2'h2
`define MODE_PREINC 2'h3
`define PTR_WIDTH 21
`define HOLD_SEL_BITS 3
`define PTR_RESET 21'h000000
`define LATCH_RESET 8'h00
`define PHASE_Q1 2'h0
`define PHASE_Q2 2'h1
`define PHASE_Q3 2'h2
`define PHASE_Q4 2'h3
`endif

// file: test/prog_mem_model.sv
/* program memory model: each word built from its own address; read at once */
module prog_mem_model (
   // read port
   input logic [19:0] mem_addr,
   output logic [15:0] mem_rdata);
   timeunit 1ns / 1ns;
   assign mem_rdata = {mem_addr[7:0] ^ 8'hC3, mem_addr[7:0] ^ 8'h3C};
endmodule // prog_mem_model

// file: test/table_access_monitor.sv
/* assertions on table_access ports; attempts that meet a frozen cycle are dropped */
module table_access_monitor (
   // watched ports
   input logic mclk,
   input logic rst_n,
   input logic clk_en,
   input logic [15:0] instr,
   input logic instr_valid,
   input logic [20:0] table_pointer,
   input logic [7:0] table_latch,
   input logic hold_wr,
   input logic busy,
   input logic done);
   timeunit 1ns / 1ns;
   logic [20:0] p0;
   wire tk = clk_en && instr_valid && !busy && instr[15:3] == 13'h1;
   wire [20:0] st = instr[1] ? {{20{~instr[0]}}, 1'h1} : {20'h0, instr[0]};
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n || !clk_en);
   always @(posedge mclk) if (tk) p0 <= table_pointer + st;
   chk_take_busy: assert property (tk |=> busy [*7] ##1 !busy) else $error("busy");
   chk_done_time: assert property (tk |-> ##8 done) else $error("done");
   chk_done_once: assert property (done |=> !done) else $error("pulse");
   chk_read_only: assert property (tk && !instr[2] |-> ##8 !hold_wr) else $error("wr");
   chk_write_hit: assert property (tk && instr[2] |-> ##8 hold_wr) else $error("no wr");
   chk_latch_kept: assert property (hold_wr |-> $stable(table_latch)) else $error("latch");
   chk_ptr_step: assert property (done |-> table_pointer == p0) else $error("step");
   chk_ptr_idle: assert property (!busy && !tk |=> $stable(table_pointer)) else $error("ptr");
endmodule // table_access_monitor
bind table_access table_access_monitor mon_u (.*);

// file: test/tb_table_access.sv
/* bench for table_access; needs the program memory model beside it */
module tb_table_access;
   timeunit 1ns / 1ns;
   logic mclk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, instr_valid = 1'h0, hold_wr, busy, done;
   logic [15:0] instr = 16'h0, mem_rdata;
   logic [19:0] mem_addr;
   logic [20:0] table_pointer, ep = 21'h0, a;
   logic [7:0] table_latch, el = 8'h0;
   logic [63:0] hold_flat, eh = 64'h0;
   logic [2:0] hold_sel, es = 3'h0;
   int miscompares = 0, comparisons = 0, cyc = 0;
   table_access dut_u (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .instr(instr),
      .instr_valid(instr_valid), .mem_rdata(mem_rdata), .mem_addr(mem_addr),
      .table_pointer(table_pointer), .table_latch(table_latch), .hold_flat(hold_flat),
      .hold_wr(hold_wr), .hold_sel(hold_sel), .busy(busy), .done(done));
   prog_mem_model mem_u (.mem_addr(mem_addr), .mem_rdata(mem_rdata));
   initial forever #10 mclk = ~mclk;
   always @(posedge mclk) if (++cyc == 1500) finish_test(1);
   task automatic cmp(input logic [98:0] got, exp);
      comparisons++;
      miscompares += got !== exp;
      if (got !== exp) $display("[FAIL] %0t got %h", $time, got);
   endtask
   task automatic finish_test(input int late);
      miscompares += late;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // k above one keeps valid up while busy, which must be ignored; s frozen cycles
   task automatic run(input logic [15:0] w, input int k, input int s);
      a = ep + 21'(w[1:0] == 2'h3);
      if (w[2]) begin
         eh[a[2:0]*8 +: 8] = el;
         es = a[2:0];
      end
      else el = a[8:1] ^ (a[0] ? 8'hC3 : 8'h3C);
      ep = w[1:0] == 2'h1 ? a + 21'h1 : w[1:0] == 2'h2 ? a - 21'h1 : a;
      @(posedge mclk);
      {instr, instr_valid} <= {w, 1'h1};
      repeat (k) @(posedge mclk);
      instr_valid <= 1'h0;
      if (s > 0) begin
         @(posedge mclk);
         clk_en <= 1'h0;
         repeat (s) @(posedge mclk);
         cmp({busy, done}, 2'h2);
         clk_en <= 1'h1;
      end
      repeat (12) if (done !== 1'h1) @(negedge mclk);
      cmp({hold_wr, busy, done, table_latch, table_pointer, hold_flat, hold_sel},
          {w[2], 2'h1, el, ep, eh, es});
   endtask
   // every mode of both words; pointer wraps down through zero and back
   task automatic t_modes;
      @(negedge mclk);
      cmp({hold_wr, busy, done, table_latch, table_pointer, hold_flat, hold_sel}, 99'h0);
      for (int i = 9; i >= 0; i--)
         run(16'(40'hBA98EEFBCD >> 4 * i) & 16'hF, i == 5 ? 3 : 1, i == 2 ? 4 : 0);
   endtask
   // words beside the table range must start nothing
   task automatic t_ignore;
      @(posedge mclk);
      {instr, instr_valid} <= {16'h0010, 1'h1};
      @(posedge mclk);
      instr <= 16'h0007;
      @(posedge mclk);
      instr_valid <= 1'h0;
      repeat (2) @(negedge mclk);
      cmp({busy, done}, 2'h0);
      repeat (7) @(negedge mclk);
      cmp({hold_wr, busy, done, table_latch, table_pointer, hold_flat, hold_sel},
          {3'h0, el, ep, eh, es});
   endtask
   initial begin
      repeat (12) @(posedge mclk);
      rst_n <= 1'h1;
      t_modes();
      t_ignore();
      finish_test(0);
   end
endmodule // tb_table_access
